// [pods_stage.sv]
// PWM output stage: mode pairing, dead time, masking, polarity and
// fault brake, with its byte-wide register port.
// Assumes the generator signals and ADC event are on clk; the fault
// pin is asynchronous.
`timescale 1ns/1ns
module pods_stage #(
	parameter int CHANNELS = 6,
	parameter int DT_WIDTH = 9
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// Generator side
	input  wire logic [CHANNELS-1:0] generator_signal,
	output logic                     generator_run,
	output logic                     counter_clear,
	// Fault sources and brake flag
	input  wire logic                fault_brake_pin,
	input  wire logic                adc_compare_event,
	output logic                     fault_brake_flag,
	// Driver pins
	output logic [CHANNELS-1:0]      pwm_out
);
	localparam int PAIRS = CHANNELS / 2;

	logic [PAIRS-1:0]    pair_deadtime_on_ff;
	logic [DT_WIDTH-1:0] deadtime_count_ff;
	logic [CHANNELS-1:0] output_mask_enable_ff;
	logic [CHANNELS-1:0] output_mask_level_ff;
	logic [CHANNELS-1:0] brake_override_data_ff;
	logic [CHANNELS-1:0] output_polarity_invert_ff;
	logic [1:0]          output_mode_select_ff;
	logic                fault_pin_enable_ff;
	logic                fault_edge_select_ff;
	logic                flag_ff;
	logic                run_ff;
	logic                braked_ff;
	logic [7:0]          ctl1_other_ff;
	logic [7:0]          rdata_ff;
	logic [CHANNELS-1:0] pwm_ff;
	logic                fpin_s1_ff;
	logic                fpin_s2_ff;
	logic                fpin_clean_ff;
	logic                fpin_prev_ff;
	logic [3:0]          deb_cnt_ff;
	logic [2:0]          ta_cnt_ff;
	logic                ta_half_ff;
	logic                brake_evt;
	logic                pin_edge;
	logic                ta_open;
	logic                wr_ctl0;
	logic [CHANNELS-1:0] mode_sig;
	logic [CHANNELS-1:0] dt_sig;

	typedef enum logic [1:0] {
		PODS_TA_IDLE,
		PODS_TA_HALF,
		PODS_TA_OPEN
	} pods_ta_t;
	pods_ta_t ta_state_ff;

	// Timed-access unlock: key1 then key2 opens a short window
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ta_state_ff <= PODS_TA_IDLE;
			ta_cnt_ff   <= 3'h0;
		end else if (reg_wr && reg_addr == pods_pkg::OFS_TIMED_ACC) begin
			if (reg_wdata == pods_pkg::TA_KEY1) begin
				ta_state_ff <= PODS_TA_HALF;
			end else if (reg_wdata == pods_pkg::TA_KEY2 &&
					ta_state_ff == PODS_TA_HALF) begin
				ta_state_ff <= PODS_TA_OPEN;
				ta_cnt_ff   <= 3'(pods_pkg::TA_WINDOW_CYC);
			end else begin
				ta_state_ff <= PODS_TA_IDLE;
			end
		end else begin
			case (ta_state_ff)
				PODS_TA_OPEN: begin
					// Any protected write or timeout closes it
					if (ta_cnt_ff == 3'h1 || (reg_wr &&
							(reg_addr == pods_pkg::OFS_DT_ENABLE ||
							reg_addr == pods_pkg::OFS_DT_COUNT))) begin
						ta_state_ff <= PODS_TA_IDLE;
					end
					ta_cnt_ff <= ta_cnt_ff - 3'h1;
				end
				PODS_TA_HALF: begin
					if (reg_wr) begin
						ta_state_ff <= PODS_TA_IDLE;
					end
				end
				default: begin
					ta_state_ff <= PODS_TA_IDLE;
				end
			endcase
		end
	end
	assign ta_open = (ta_state_ff == PODS_TA_OPEN);

	// R06 dead-time writes need unlock
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pair_deadtime_on_ff <= '0;
			deadtime_count_ff   <= '0;
		end else if (reg_wr && ta_open) begin
			// R01 R03 enable bits and count msb
			if (reg_addr == pods_pkg::OFS_DT_ENABLE) begin
				pair_deadtime_on_ff <= reg_wdata[PAIRS-1:0];
				deadtime_count_ff[8] <= reg_wdata[pods_pkg::DT_MSB_BIT];
			end else if (reg_addr == pods_pkg::OFS_DT_COUNT) begin
				deadtime_count_ff[7:0] <= reg_wdata;
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			output_mask_enable_ff     <= '0;
			output_mask_level_ff      <= '0;
			brake_override_data_ff    <= '0;
			output_polarity_invert_ff <= '0;
			output_mode_select_ff     <= pods_pkg::MODE_INDEP;
			fault_pin_enable_ff       <= 1'b0;
			fault_edge_select_ff      <= 1'b0;
			ctl1_other_ff             <= pods_pkg::RST_BYTE;
		end else if (reg_wr) begin
			// R08 mask enables
			if (reg_addr == pods_pkg::OFS_MASK_ENABLE) begin
				output_mask_enable_ff <= reg_wdata[CHANNELS-1:0];
			end else if (reg_addr == pods_pkg::OFS_MASK_LEVEL) begin
				output_mask_level_ff <= reg_wdata[CHANNELS-1:0];
			end else if (reg_addr == pods_pkg::OFS_BRAKE_DATA) begin
				brake_override_data_ff <= reg_wdata[CHANNELS-1:0];
				fault_edge_select_ff <= reg_wdata[pods_pkg::EDGE_SEL_BIT];
			end else if (reg_addr == pods_pkg::OFS_POLARITY) begin
				output_polarity_invert_ff <= reg_wdata[CHANNELS-1:0];
			end else if (reg_addr == pods_pkg::OFS_CONTROL1) begin
				output_mode_select_ff <= reg_wdata[7:6];
				fault_pin_enable_ff <= reg_wdata[pods_pkg::FAULT_EN_BIT];
				ctl1_other_ff <= reg_wdata;
			end
		end
	end

	// R18 pin synchroniser then eight-clock debounce
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fpin_s1_ff    <= 1'b1;
			fpin_s2_ff    <= 1'b1;
			fpin_clean_ff <= 1'b1;
			fpin_prev_ff  <= 1'b1;
			deb_cnt_ff    <= 4'h0;
		end else begin
			fpin_s1_ff   <= fault_brake_pin;
			fpin_s2_ff   <= fpin_s1_ff;
			fpin_prev_ff <= fpin_clean_ff;
			if (fpin_s2_ff == fpin_clean_ff) begin
				deb_cnt_ff <= 4'h0;
			end else if (deb_cnt_ff == 4'(pods_pkg::DEBOUNCE_CYC - 1)) begin
				fpin_clean_ff <= fpin_s2_ff;
				deb_cnt_ff    <= 4'h0;
			end else begin
				deb_cnt_ff <= deb_cnt_ff + 4'h1;
			end
		end
	end

	// R17 R22 edge of chosen direction on the clean level
	assign pin_edge = fault_edge_select_ff ?
		(fpin_clean_ff && !fpin_prev_ff) :
		(!fpin_clean_ff && fpin_prev_ff);
	// R11 R19 pin gated by enable, ADC event always
	assign brake_evt = (fault_pin_enable_ff && pin_edge) ||
		adc_compare_event;

	assign wr_ctl0 = reg_wr && reg_addr == pods_pkg::OFS_CONTROL0;

	// R13 R16 run bit cleared by brake, set by software
	always_ff @(posedge clk) begin
		if (!nrst) begin
			run_ff    <= 1'b0;
			braked_ff <= 1'b0;
		end else if (brake_evt) begin
			run_ff    <= 1'b0;
			braked_ff <= 1'b1;
		end else if (wr_ctl0) begin
			run_ff <= reg_wdata[pods_pkg::RUN_BIT];
			if (reg_wdata[pods_pkg::RUN_BIT]) begin
				braked_ff <= 1'b0;
			end
		end
	end

	// R15 flag set wins over software clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
		end else if (brake_evt) begin
			flag_ff <= 1'b1;
		end else if (reg_wr && reg_addr == pods_pkg::OFS_BRAKE_DATA &&
				!reg_wdata[pods_pkg::FLAG_BIT]) begin
			flag_ff <= 1'b0;
		end
	end

	// R14 counter reset pulse on brake
	assign counter_clear    = brake_evt;
	assign generator_run    = run_ff;
	assign fault_brake_flag = flag_ff;

	// Per-pair pairing and dead time
	for (genvar p = 0; p < PAIRS; p++) begin : g_pair
		logic [DT_WIDTH-1:0] cnt_a_ff;
		logic [DT_WIDTH-1:0] cnt_b_ff;
		logic                prev_a_ff;
		logic                prev_b_ff;
		logic                raw_a;
		logic                raw_b;
		logic                dt_on;

		// R20 R07 odd channel per mode
		always_comb begin
			raw_a = generator_signal[2*p];
			case (output_mode_select_ff)
				pods_pkg::MODE_COMPL: raw_b = !generator_signal[2*p];
				pods_pkg::MODE_SYNC:  raw_b = generator_signal[2*p];
				default:              raw_b = generator_signal[2*p+1];
			endcase
		end
		assign mode_sig[2*p]   = raw_a;
		assign mode_sig[2*p+1] = raw_b;
		// R02 dead time only when complementary
		assign dt_on = pair_deadtime_on_ff[p] &&
			output_mode_select_ff == pods_pkg::MODE_COMPL;

		// R23 R04 reload on rise, count count+1 clocks
		always_ff @(posedge clk) begin
			if (!nrst) begin
				cnt_a_ff  <= '0;
				cnt_b_ff  <= '0;
				prev_a_ff <= 1'b0;
				prev_b_ff <= 1'b0;
			end else begin
				prev_a_ff <= raw_a;
				prev_b_ff <= raw_b;
				// Load count, not count+1: the prev gate adds the extra clock
				if (raw_a && !prev_a_ff) begin
					cnt_a_ff <= deadtime_count_ff;
				end else if (cnt_a_ff != '0) begin
					cnt_a_ff <= cnt_a_ff - DT_WIDTH'(1);
				end
				if (raw_b && !prev_b_ff) begin
					cnt_b_ff <= deadtime_count_ff;
				end else if (cnt_b_ff != '0) begin
					cnt_b_ff <= cnt_b_ff - DT_WIDTH'(1);
				end
			end
		end

		// R21 rising edge held low until underflow
		assign dt_sig[2*p] = dt_on ?
			(raw_a && prev_a_ff && cnt_a_ff == '0) : raw_a;
		assign dt_sig[2*p+1] = dt_on ?
			(raw_b && prev_b_ff && cnt_b_ff == '0) : raw_b;
	end

	// R24 brake over mask over mode, polarity last
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwm_ff <= '0;
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (braked_ff) begin
					// R12 brake data override
					pwm_ff[c] <= brake_override_data_ff[c] ^
						output_polarity_invert_ff[c];
				end else if (output_mask_enable_ff[c]) begin
					// R09 R10 mask level through polarity
					pwm_ff[c] <= output_mask_level_ff[c] ^
						output_polarity_invert_ff[c];
				end else begin
					pwm_ff[c] <= dt_sig[c] ^
						output_polarity_invert_ff[c];
				end
			end
		end
	end
	assign pwm_out = pwm_ff;

	// Read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_ff <= pods_pkg::RST_BYTE;
		end else if (reg_rd) begin
			if (reg_addr == pods_pkg::OFS_DT_ENABLE) begin
				rdata_ff <= {3'h0, deadtime_count_ff[8], 1'b0,
					pair_deadtime_on_ff};
			end else if (reg_addr == pods_pkg::OFS_DT_COUNT) begin
				rdata_ff <= deadtime_count_ff[7:0];
			end else if (reg_addr == pods_pkg::OFS_MASK_ENABLE) begin
				rdata_ff <= {2'h0, output_mask_enable_ff};
			end else if (reg_addr == pods_pkg::OFS_MASK_LEVEL) begin
				rdata_ff <= {2'h0, output_mask_level_ff};
			end else if (reg_addr == pods_pkg::OFS_BRAKE_DATA) begin
				rdata_ff <= {flag_ff, fault_edge_select_ff,
					brake_override_data_ff};
			end else if (reg_addr == pods_pkg::OFS_POLARITY) begin
				rdata_ff <= {2'h0, output_polarity_invert_ff};
			end else if (reg_addr == pods_pkg::OFS_CONTROL0) begin
				rdata_ff <= {run_ff, 7'h0};
			end else if (reg_addr == pods_pkg::OFS_CONTROL1) begin
				rdata_ff <= {output_mode_select_ff, ctl1_other_ff[5:4],
					fault_pin_enable_ff, ctl1_other_ff[2:0]};
			end else if (reg_addr == pods_pkg::OFS_TIMED_ACC) begin
				rdata_ff <= {7'h0, ta_open};
			end else begin
				rdata_ff <= pods_pkg::RST_BYTE;
			end
		end
	end
	assign reg_rdata = rdata_ff;
endmodule // pods_stage

// [pods_pkg.sv]
// Constants of the PWM output stage: register offsets, field positions,
// reset values and timing counts.
// Assumes a byte-wide register port on the system clock.
// Notes on behaviour
// R01 - Per-pair dead-time enable at bits 0..2
// R02 - Dead time only in complementary mode
// R03 - Nine-bit count, msb in enable bit 4
// R04 - Dead time equals count plus one clocks
// R05 - Software changes count only while stopped; the code checks only the timed-access unlock, not the run bit
// R06 - Dead-time registers need timed-access unlock
// R07 - Mode 10: odd channel copies even partner
// R08 - Mask enable per channel, clear at reset
// R09 - Masked channel drives its mask level
// R10 - Polarity inversion still applies when masked
// R11 - Fault pin acts only when enabled
// R12 - Brake drives each channel from brake data
// R13 - Brake clears the run bit
// R14 - Brake resets the period counter
// R15 - Brake sets flag, software clears it
// R16 - Override holds until run set again
// R17 - Pin triggers on selected edge
// R18 - Fault pin debounced over eight clocks
// R19 - ADC compare event brakes identically
// R20 - Mode 00 independent, 01 complementary
// R21 - Rising pair edge waits for underflow
// R22 - Edge select 0 falling, 1 rising
// R23 - Counter reloads on each rising edge
// R24 - Brake over mask over mode, polarity last
package pods_pkg;
	// Register offsets
	localparam logic [7:0] OFS_DT_ENABLE   = 8'h00_F9;
	localparam logic [7:0] OFS_DT_COUNT    = 8'h00_FA;
	localparam logic [7:0] OFS_MASK_ENABLE = 8'h00_FB;
	localparam logic [7:0] OFS_MASK_LEVEL  = 8'h00_FC;
	localparam logic [7:0] OFS_BRAKE_DATA  = 8'h00_D7;
	localparam logic [7:0] OFS_POLARITY    = 8'h00_D6;
	localparam logic [7:0] OFS_CONTROL0    = 8'h00_D8;
	localparam logic [7:0] OFS_CONTROL1    = 8'h00_DF;
	localparam logic [7:0] OFS_TIMED_ACC   = 8'h00_C7;
	// Field positions
	localparam int DT_MSB_BIT      = 4;
	localparam int RUN_BIT         = 7;
	localparam int FAULT_EN_BIT    = 3;
	localparam int MODE_LO_BIT     = 6;
	localparam int FLAG_BIT        = 7;
	localparam int EDGE_SEL_BIT    = 6;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00_00;
	// Mode encodings
	localparam logic [1:0] MODE_INDEP = 2'h0;
	localparam logic [1:0] MODE_COMPL = 2'h1;
	localparam logic [1:0] MODE_SYNC  = 2'h2;
	// Timed-access unlock bytes and window
	localparam logic [7:0] TA_KEY1 = 8'h00_AA;
	localparam logic [7:0] TA_KEY2 = 8'h00_55;
	localparam int TA_WINDOW_CYC   = 4;
	// Fault pin debounce time and clock period
	localparam int DEBOUNCE_CLKS  = 8;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int DEBOUNCE_NS    = DEBOUNCE_CLKS * CLK_PERIOD_NS;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_NS / CLK_PERIOD_NS;
endpackage

// [pods_checker.sv]
// Checker of the PWM output stage: brake, mask and mode relations.
// Assumes one clock domain; bound to every pods_stage instance.
`timescale 1ns/1ns
module pods_checker #(
	parameter int CHANNELS = 6
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                nrst,
	// Register port
	input wire logic [7:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	// Stage outputs and their causes
	input wire logic [CHANNELS-1:0] generator_signal,
	input wire logic                generator_run,
	input wire logic                counter_clear,
	input wire logic                adc_compare_event,
	input wire logic                fault_brake_flag,
	input wire logic [CHANNELS-1:0] pwm_out
);
	logic [CHANNELS-1:0]      brk_ff, pol_ff, men_ff, mlv_ff;
	logic [1:0]               mode_ff, quiet_ff;
	logic                     bon_ff;
	wire logic [CHANNELS-1:0] lvl = pwm_out ^ pol_ff;
	wire logic                wr_run = reg_wr && reg_wdata[pods_pkg::RUN_BIT]
		&& reg_addr == pods_pkg::OFS_CONTROL0;
	wire logic                wr_clr = reg_wr && !reg_wdata[pods_pkg::FLAG_BIT]
		&& reg_addr == pods_pkg::OFS_BRAKE_DATA;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Shadow copies of the plain registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{brk_ff, pol_ff, men_ff, mlv_ff, mode_ff} <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
			pods_pkg::OFS_BRAKE_DATA: brk_ff <= reg_wdata[CHANNELS-1:0];
			pods_pkg::OFS_POLARITY: pol_ff <= reg_wdata[CHANNELS-1:0];
			pods_pkg::OFS_MASK_ENABLE: men_ff <= reg_wdata[CHANNELS-1:0];
			pods_pkg::OFS_MASK_LEVEL: mlv_ff <= reg_wdata[CHANNELS-1:0];
			pods_pkg::OFS_CONTROL1: mode_ff <= reg_wdata[7:6];
			default: ;
			endcase
		end
	end
	// Brake override stands from the brake until run is set again
	always_ff @(posedge clk) begin
		if (!nrst)
			bon_ff <= 1'b0;
		else if (counter_clear)
			bon_ff <= 1'b1;
		else if (wr_run)
			bon_ff <= 1'b0;
	end
	// Settled cycles since the last write or brake, held at zero while the brake override stands, saturating
	always_ff @(posedge clk) begin
		if (!nrst || reg_wr || counter_clear || bon_ff)
			quiet_ff <= 2'h0;
		else if (quiet_ff != 2'h3)
			quiet_ff <= quiet_ff + 2'h1;
	end
	a_adc_clears: assert property (adc_compare_event |-> counter_clear)
		else $error("no counter clear on adc event");
	a_brake_flags: assert property (counter_clear
		|=> fault_brake_flag && !generator_run)
		else $error("brake left run set or flag clear");
	a_brake_data: assert property (counter_clear |-> ##2 lvl == brk_ff)
		else $error("pins do not show brake data");
	a_brake_hold: assert property (bon_ff && $past(bon_ff)
		|-> lvl == brk_ff)
		else $error("brake override released early");
	a_flag_sticky: assert property (fault_brake_flag && !wr_clr
		|=> fault_brake_flag)
		else $error("flag dropped without software clear");
	a_mask_level: assert property (quiet_ff == 2'h3
		|-> (lvl & men_ff) == (mlv_ff & men_ff))
		else $error("masked channel not at mask level");
	a_indep_follow: assert property (quiet_ff == 2'h3 && generator_run
		&& mode_ff == pods_pkg::MODE_INDEP
		|-> (lvl & ~men_ff) == ($past(generator_signal) & ~men_ff))
		else $error("independent channel not following generator");
	a_compl_excl: assert property (quiet_ff == 2'h3 && generator_run
		&& mode_ff == pods_pkg::MODE_COMPL && men_ff[1:0] == 2'h0
		|-> !(lvl[0] && lvl[1]))
		else $error("complementary pair both on");
endmodule // pods_checker

bind pods_stage pods_checker #(.CHANNELS(CHANNELS)) pods_checker_i (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .generator_signal(generator_signal),
	.generator_run(generator_run), .counter_clear(counter_clear),
	.adc_compare_event(adc_compare_event),
	.fault_brake_flag(fault_brake_flag), .pwm_out(pwm_out)
);

// [pods_gate_drv.sv]
// Gate driver of the half bridges, reporting trips on its fault line.
// Assumes the trip request comes on the system clock.
`timescale 1ns/1ns
module pods_gate_drv (
	// Clock
	input  wire logic clk,
	// Trip request from the bench
	input  wire logic trip,
	// Fault line, idle high
	output logic      nfault
);
	initial nfault = 1'b1;
	// trip held whole
	// Fault line is held low for the whole trip, never a glitch
	always @(posedge clk)
		nfault <= ~trip;
endmodule // pods_gate_drv

// [pods_stage_tb.sv]
// Bench of the PWM output stage: registers, modes, dead time, brakes.
// Assumes the gate driver model drives the fault pin.
`timescale 1ns/1ns
module pods_stage_tb;
	localparam logic [5:0] MEN = 6'h30;
	localparam logic [5:0] MLV = 6'h10;
	localparam logic [5:0] POL = 6'h21;
	logic       clk, nrst, reg_wr, reg_rd, adc, trip, chk, ck_d, rd_d, nfault;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] gen, pwm_out, g, s;
	logic [7:0] rq[$];
	logic [5:0] pq[$];
	int         err_count, tests_run;

	pods_stage pods_stage_i (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.generator_signal(gen), .generator_run(), .counter_clear(),
		.fault_brake_pin(nfault), .adc_compare_event(adc),
		.fault_brake_flag(), .pwm_out(pwm_out)
	);
	pods_gate_drv pods_gate_drv_i (.clk(clk), .trip(trip), .nfault(nfault));

	// Clock of 10 ns
	always #5 clk = ~clk;

	task automatic cmp(logic [7:0] got, logic [7:0] e);
		tests_run++;
		if (got !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, e);
		end
	endtask
	// Match read data and pin levels with the oldest note
	always @(posedge clk) begin
		rd_d <= reg_rd;
		ck_d <= chk;
		if (rd_d)
			cmp(reg_rdata, rq.pop_front());
		if (ck_d)
			cmp({2'h0, pwm_out}, {2'h0, pq.pop_front()});
	end
	task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
		{reg_wr, reg_rd, chk} <= {w, r, 1'b0};
		{reg_addr, reg_wdata} <= {a, d};
		@(posedge clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic idle(int n);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (n) @(posedge clk);
	endtask
	// Pins are checked as they stand after the next edge
	task automatic pchk(logic [5:0] e);
		pq.push_back(e);
		{reg_wr, reg_rd, chk} <= 3'h1;
		@(posedge clk);
	endtask
	task automatic ta(logic [7:0] a, logic [7:0] d);
		wr(pods_pkg::OFS_TIMED_ACC, pods_pkg::TA_KEY1);
		wr(pods_pkg::OFS_TIMED_ACC, pods_pkg::TA_KEY2);
		wr(a, d);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial begin
		{clk, nrst, reg_wr, reg_rd, adc, trip, chk, ck_d, rd_d} = '0;
		{reg_addr, reg_wdata, gen} = '0;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'hc31f_5dcb));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset values, unmapped read, locked writes, then unlock
		rd(pods_pkg::OFS_MASK_ENABLE, 8'h00);
		rd(pods_pkg::OFS_MASK_LEVEL, 8'h00);
		rd(8'h10, 8'h00);
		wr(pods_pkg::OFS_DT_COUNT, 8'h55);
		rd(pods_pkg::OFS_DT_COUNT, 8'h00);
		ta(pods_pkg::OFS_DT_COUNT, 8'h03);
		ta(pods_pkg::OFS_DT_ENABLE, 8'h11);
		rd(pods_pkg::OFS_DT_COUNT, 8'h03);
		rd(pods_pkg::OFS_DT_ENABLE, 8'h11);
		wr(pods_pkg::OFS_MASK_ENABLE, {2'h0, MEN});
		wr(pods_pkg::OFS_MASK_LEVEL, {2'h0, MLV});
		wr(pods_pkg::OFS_POLARITY, {2'h0, POL});
		wr(pods_pkg::OFS_CONTROL0, 8'h80);
		// Independent then synchronous, masked, no dead time
		for (int m = 0; m < 2; m++) begin
			wr(pods_pkg::OFS_CONTROL1, m ? 8'h80 : 8'h00);
			idle(2);
			repeat (8) begin
				g = 6'($urandom);
				s = m ? {g[4], g[4], g[2], g[2], g[0], g[0]} : g;
				gen <= g;
				pchk(((s & ~MEN) | (MLV & MEN)) ^ POL);
			end
		end
		// Complementary: pair a delayed by count plus one, pair b not
		gen <= 6'h00;
		wr(pods_pkg::OFS_MASK_ENABLE, 8'h00);
		wr(pods_pkg::OFS_POLARITY, 8'h00);
		wr(pods_pkg::OFS_CONTROL1, 8'h40);
		idle(270);
		gen <= 6'h05;
		repeat (259) @(posedge clk);
		pchk(6'h24);
		pchk(6'h25);
		// Adc brake, flag clear keeps override, run releases it
		wr(pods_pkg::OFS_BRAKE_DATA, 8'h0a);
		adc <= 1'b1;
		idle(0);
		adc <= 1'b0;
		pchk(6'h0a);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'h8a);
		rd(pods_pkg::OFS_CONTROL0, 8'h00);
		wr(pods_pkg::OFS_BRAKE_DATA, 8'h0a);
		idle(1);
		pchk(6'h0a);
		wr(pods_pkg::OFS_CONTROL0, 8'h80);
		idle(270);
		pchk(6'h25);
		// Fault pin: disabled, too short, falling, then rising select
		trip <= 1'b1;
		idle(20);
		trip <= 1'b0;
		idle(20);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'h0a);
		wr(pods_pkg::OFS_CONTROL1, 8'h48);
		trip <= 1'b1;
		idle(3);
		trip <= 1'b0;
		idle(20);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'h0a);
		trip <= 1'b1;
		idle(20);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'h8a);
		wr(pods_pkg::OFS_CONTROL0, 8'h80);
		wr(pods_pkg::OFS_BRAKE_DATA, 8'h4a);
		idle(20);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'h4a);
		trip <= 1'b0;
		idle(20);
		rd(pods_pkg::OFS_BRAKE_DATA, 8'hca);
		idle(2);
		finish_test();
	end
endmodule // pods_stage_tb
